// [hw/tcc_defines.vh]
// Purpose: constants for the timer capture/compare block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   offsets are byte addresses
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH
`define TCC_OFS_CTRL_ONE   8'h00
`define TCC_OFS_CTRL_TWO   8'h04
`define TCC_OFS_STATUS     8'h08
`define TCC_OFS_CAP1_HI    8'h0C
`define TCC_OFS_CAP1_LO    8'h10
`define TCC_OFS_CAP2_HI    8'h14
`define TCC_OFS_CAP2_LO    8'h18
`define TCC_OFS_CMP1_HI    8'h1C
`define TCC_OFS_CMP1_LO    8'h20
`define TCC_OFS_CMP2_HI    8'h24
`define TCC_OFS_CMP2_LO    8'h28
`define TCC_OFS_CNT_HI     8'h2C
`define TCC_OFS_CNT_LO     8'h30
`define TCC_OFS_ALT_HI     8'h34
`define TCC_OFS_ALT_LO     8'h38
// control one bits
`define TCC_C1_CAP_EDGE1   0
`define TCC_C1_LVL1        1
`define TCC_C1_LVL2        2
`define TCC_C1_FORCE1      3
`define TCC_C1_FORCE2      4
`define TCC_C1_OVF_IE      5
`define TCC_C1_CMP_IE      6
`define TCC_C1_CAP_IE      7
// control two bits
`define TCC_C2_CAP_EDGE2   0
`define TCC_C2_EXT_EDGE    1
`define TCC_C2_PRESC_LO    2
`define TCC_C2_PRESC_HI    3
`define TCC_C2_PWM         4
`define TCC_C2_ONE_PULSE   5
`define TCC_C2_OUT_EN2     6
`define TCC_C2_OUT_EN1     7
// status bits
`define TCC_ST_CMP2        3
`define TCC_ST_OVF         5
`define TCC_ST_CMP1        6
`define TCC_ST_CAP1        7
`define TCC_ST_CAP2        4
`define TCC_CMP_RESET      16'h8000
`define TCC_CNT_RESET      16'hFFFC
`define TCC_CNT_TOP        16'hFFFF
`define TCC_PRESC_EXT      2'h3
`define TCC_RESP_OKAY      2'h0
`define TCC_RESP_SLVERR    2'h2
`endif

// [hw/tcc_timer_capture_compare.v]
// Purpose: 16-bit timer input capture, output compare, overflow, AXI4-Lite regs
// Assumes: aclk is the cpu clock; pins asynchronous; cpu_mask from cpu core
// Notes:   one pulse / pwm waveform generation is not modelled
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "tcc_defines.vh"
module tcc_timer_capture_compare (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        capture_pin_one,
  input  wire        capture_pin_two,
  input  wire        ext_clk_pin,
  input  wire        cpu_mask,
  output reg         compare_pin_one,
  output reg         compare_pin_one_oe,
  output reg         compare_pin_two,
  output reg         compare_pin_two_oe,
  output reg         timer_irq
);
  reg  [7:0]  ctrl_one_r;
  reg  [7:0]  ctrl_two_r;
  reg  [15:0] counter_r;
  reg  [15:0] cap_one_r;
  reg  [15:0] cap_two_r;
  reg  [15:0] cmp_one_r;
  reg  [15:0] cmp_two_r;
  reg         cap_flag_one_r;
  reg         cap_flag_two_r;
  reg         cmp_flag_one_r;
  reg         cmp_flag_two_r;
  reg         ovf_flag_r;
  reg         cap_lock_one_r;
  reg         cap_lock_two_r;
  reg         cmp_inh_one_r;
  reg         cmp_inh_two_r;
  reg  [4:0]  armed_r;
  reg  [7:0]  cnt_lo_buf_r;
  reg         cnt_buf_valid_r;
  reg  [2:0]  presc_r;
  reg  [1:0]  cap_one_sync_r;
  reg  [1:0]  cap_two_sync_r;
  reg  [1:0]  ext_sync_r;
  reg         cap_one_prev_r;
  reg         cap_two_prev_r;
  reg         ext_prev_r;
  reg         cap_one_pend_r;
  reg         cap_two_pend_r;
  reg  [7:0]  awaddr_r;
  reg         aw_held_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         w_held_r;
  reg  [1:0]  presc_sel;
  reg         tick;
  reg         mode_alt;
  reg         wr_go;
  reg         rd_go;
  reg  [7:0]  wr_addr;
  reg  [7:0]  wr_byte;
  reg         wr_en;
  reg         cap_one_edge;
  reg         cap_two_edge;
  reg         cap_one_take;
  reg         cap_two_take;
  reg         match_one_now;
  reg         match_two_now;
  reg         match_one_fire;
  reg         match_two_fire;
  reg  [7:0]  rd_byte;
  reg         rd_ok;
  reg         wr_ok;
  reg  [7:0]  status_val;

  // byte write from the lowest strobed lane is not used: registers sit in lane 0
  function edge_hit;
    input prev;
    input cur;
    input rising;
    begin
      edge_hit = rising ? (~prev & cur) : (prev & ~cur);
    end
  endfunction

  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a <= `TCC_OFS_ALT_LO) && (a[1:0] == 2'h0);
    end
  endfunction

  always @* begin
    presc_sel = {ctrl_two_r[`TCC_C2_PRESC_HI], ctrl_two_r[`TCC_C2_PRESC_LO]};
    mode_alt  = ctrl_two_r[`TCC_C2_PWM] | ctrl_two_r[`TCC_C2_ONE_PULSE];
    case (presc_sel)
      2'h0:    tick = (presc_r[0] == 1'b1);
      2'h1:    tick = (presc_r[1:0] == 2'h3);
      2'h2:    tick = (presc_r == 3'h7);
      default: tick = edge_hit(ext_prev_r, ext_sync_r[1], ctrl_two_r[`TCC_C2_EXT_EDGE]);
    endcase
    wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
    wr_addr = awaddr_r;
    wr_byte = wdata_r[7:0];
    wr_en   = wstrb_r[0];
    wr_ok   = addr_known(wr_addr);
    rd_go   = s_axi_arvalid & s_axi_arready;
    rd_ok   = addr_known(s_axi_araddr);
    status_val = 8'h00;
    status_val[`TCC_ST_CAP1] = cap_flag_one_r;
    status_val[`TCC_ST_CMP1] = cmp_flag_one_r;
    status_val[`TCC_ST_OVF]  = ovf_flag_r;
    status_val[`TCC_ST_CAP2] = cap_flag_two_r;
    status_val[`TCC_ST_CMP2] = cmp_flag_two_r;
    case (s_axi_araddr)
      `TCC_OFS_CTRL_ONE: rd_byte = ctrl_one_r;
      `TCC_OFS_CTRL_TWO: rd_byte = ctrl_two_r;
      `TCC_OFS_STATUS:   rd_byte = status_val;
      `TCC_OFS_CAP1_HI:  rd_byte = cap_one_r[15:8];
      `TCC_OFS_CAP1_LO:  rd_byte = cap_one_r[7:0];
      `TCC_OFS_CAP2_HI:  rd_byte = cap_two_r[15:8];
      `TCC_OFS_CAP2_LO:  rd_byte = cap_two_r[7:0];
      `TCC_OFS_CMP1_HI:  rd_byte = cmp_one_r[15:8];
      `TCC_OFS_CMP1_LO:  rd_byte = cmp_one_r[7:0];
      `TCC_OFS_CMP2_HI:  rd_byte = cmp_two_r[15:8];
      `TCC_OFS_CMP2_LO:  rd_byte = cmp_two_r[7:0];
      `TCC_OFS_CNT_HI,
      `TCC_OFS_ALT_HI:   rd_byte = counter_r[15:8];
      `TCC_OFS_CNT_LO,
      `TCC_OFS_ALT_LO:   rd_byte = cnt_buf_valid_r ? cnt_lo_buf_r : counter_r[7:0];
      default:           rd_byte = 8'h00;
    endcase
    // pins feed capture, pin one only outside pwm / one pulse, even if driven as outputs
    cap_one_edge = edge_hit(cap_one_prev_r, cap_one_sync_r[1], ctrl_one_r[`TCC_C1_CAP_EDGE1]);
    cap_two_edge = edge_hit(cap_two_prev_r, cap_two_sync_r[1], ctrl_two_r[`TCC_C2_CAP_EDGE2]);
    // capture lands on next timer tick, flag 3..4 clocks after pin with the /2 prescaler, later with /4 and /8
    cap_one_take = (cap_one_pend_r | cap_one_edge) & tick & ~cap_lock_one_r & ~mode_alt;
    cap_two_take = (cap_two_pend_r | cap_two_edge) & tick & ~cap_lock_two_r;
    match_one_now  = (counter_r == cmp_one_r) & ~cmp_inh_one_r;
    match_two_now  = (counter_r == cmp_two_r) & ~cmp_inh_two_r;
    // div2: first cycle of the equal count; slower clocks: tick leaving it
    match_one_fire = match_one_now & ((presc_sel == 2'h0) ? ~tick : tick);
    match_two_fire = match_two_now & ((presc_sel == 2'h0) ? ~tick : tick);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `TCC_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      ctrl_one_r <= 8'h00;
      ctrl_two_r <= 8'h00;
      counter_r  <= `TCC_CNT_RESET;
      cap_one_r  <= 16'h0000;
      cap_two_r  <= 16'h0000;
      cmp_one_r  <= `TCC_CMP_RESET;
      cmp_two_r  <= `TCC_CMP_RESET;
      cap_flag_one_r <= 1'b0;
      cap_flag_two_r <= 1'b0;
      cmp_flag_one_r <= 1'b0;
      cmp_flag_two_r <= 1'b0;
      ovf_flag_r     <= 1'b0;
      cap_lock_one_r <= 1'b0;
      cap_lock_two_r <= 1'b0;
      cmp_inh_one_r  <= 1'b0;
      cmp_inh_two_r  <= 1'b0;
      armed_r        <= 5'h00;
      cnt_lo_buf_r   <= 8'h00;
      cnt_buf_valid_r <= 1'b0;
      presc_r        <= 3'h0;
      cap_one_sync_r <= 2'h0;
      cap_two_sync_r <= 2'h0;
      ext_sync_r     <= 2'h0;
      cap_one_prev_r <= 1'b0;
      cap_two_prev_r <= 1'b0;
      ext_prev_r     <= 1'b0;
      cap_one_pend_r <= 1'b0;
      cap_two_pend_r <= 1'b0;
      compare_pin_one    <= 1'b0;
      compare_pin_two    <= 1'b0;
      compare_pin_one_oe <= 1'b0;
      compare_pin_two_oe <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      cap_one_sync_r <= {cap_one_sync_r[0], capture_pin_one};
      cap_two_sync_r <= {cap_two_sync_r[0], capture_pin_two};
      ext_sync_r     <= {ext_sync_r[0], ext_clk_pin};
      cap_one_prev_r <= cap_one_sync_r[1];
      cap_two_prev_r <= cap_two_sync_r[1];
      ext_prev_r     <= ext_sync_r[1];
      presc_r <= presc_r + 3'h1;
      cap_one_pend_r <= (cap_one_pend_r | cap_one_edge) & ~tick;
      cap_two_pend_r <= (cap_two_pend_r | cap_two_edge) & ~tick;
      if (tick) begin
        counter_r <= counter_r + 16'h0001;
      end
      // write channel handshake: address and data taken in either order
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held_r & w_held_r & ~s_axi_bvalid) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        if (s_axi_araddr == `TCC_OFS_STATUS)
          armed_r <= status_val[7:3];          // first step of flag clearing
        if (s_axi_araddr == `TCC_OFS_CAP1_HI) cap_lock_one_r <= 1'b1;
        if (s_axi_araddr == `TCC_OFS_CAP2_HI) cap_lock_two_r <= 1'b1;
        if (s_axi_araddr == `TCC_OFS_CNT_HI || s_axi_araddr == `TCC_OFS_ALT_HI) begin
          if (!cnt_buf_valid_r)
            cnt_lo_buf_r <= counter_r[7:0];
          cnt_buf_valid_r <= 1'b1;
        end
        if (s_axi_araddr == `TCC_OFS_CNT_LO || s_axi_araddr == `TCC_OFS_ALT_LO)
          cnt_buf_valid_r <= 1'b0;
      end
      // second step of clearing: access to the matching low byte
      if ((rd_go && s_axi_araddr == `TCC_OFS_CAP1_LO) ||
          (aw_held_r && w_held_r && !s_axi_bvalid && awaddr_r == `TCC_OFS_CAP1_LO)) begin
        if (armed_r[`TCC_ST_CAP1-3]) cap_flag_one_r <= 1'b0;
        armed_r[`TCC_ST_CAP1-3] <= 1'b0;
      end
      if ((rd_go && s_axi_araddr == `TCC_OFS_CAP2_LO) ||
          (aw_held_r && w_held_r && !s_axi_bvalid && awaddr_r == `TCC_OFS_CAP2_LO)) begin
        if (armed_r[`TCC_ST_CAP2-3]) cap_flag_two_r <= 1'b0;
        armed_r[`TCC_ST_CAP2-3] <= 1'b0;
      end
      if ((rd_go && s_axi_araddr == `TCC_OFS_CMP1_LO) ||
          (aw_held_r && w_held_r && !s_axi_bvalid && awaddr_r == `TCC_OFS_CMP1_LO)) begin
        if (armed_r[`TCC_ST_CMP1-3]) cmp_flag_one_r <= 1'b0;
        armed_r[`TCC_ST_CMP1-3] <= 1'b0;
      end
      if ((rd_go && s_axi_araddr == `TCC_OFS_CMP2_LO) ||
          (aw_held_r && w_held_r && !s_axi_bvalid && awaddr_r == `TCC_OFS_CMP2_LO)) begin
        if (armed_r[`TCC_ST_CMP2-3]) cmp_flag_two_r <= 1'b0;
        armed_r[`TCC_ST_CMP2-3] <= 1'b0;
      end
      if ((rd_go && s_axi_araddr == `TCC_OFS_CNT_LO) ||
          (aw_held_r && w_held_r && !s_axi_bvalid && awaddr_r == `TCC_OFS_CNT_LO)) begin
        if (armed_r[`TCC_ST_OVF-3]) ovf_flag_r <= 1'b0;
        armed_r[`TCC_ST_OVF-3] <= 1'b0;
      end
      if (rd_go && s_axi_araddr == `TCC_OFS_CAP1_LO) cap_lock_one_r <= 1'b0;
      if (rd_go && s_axi_araddr == `TCC_OFS_CAP2_LO) cap_lock_two_r <= 1'b0;
      // register writes; capture registers ignore writes
      if (wr_go & wr_en) begin
        case (wr_addr)
          `TCC_OFS_CTRL_ONE: ctrl_one_r <= wr_byte;
          `TCC_OFS_CTRL_TWO: ctrl_two_r <= wr_byte;
          `TCC_OFS_CMP1_HI: begin
            cmp_one_r[15:8] <= wr_byte;
            cmp_inh_one_r   <= 1'b1;
          end
          `TCC_OFS_CMP1_LO: begin
            cmp_one_r[7:0] <= wr_byte;
            cmp_inh_one_r  <= 1'b0;
          end
          `TCC_OFS_CMP2_HI: begin
            cmp_two_r[15:8] <= wr_byte;
            cmp_inh_two_r   <= 1'b1;
          end
          `TCC_OFS_CMP2_LO: begin
            cmp_two_r[7:0] <= wr_byte;
            cmp_inh_two_r  <= 1'b0;
          end
          `TCC_OFS_CNT_LO,
          `TCC_OFS_ALT_LO: counter_r <= `TCC_CNT_RESET;
          default: ;
        endcase
      end
      // hardware sets win over the clears above
      if (tick && counter_r == `TCC_CNT_TOP)
        ovf_flag_r <= 1'b1;
      if (cap_one_take) begin
        cap_one_r      <= counter_r;
        cap_flag_one_r <= 1'b1;
      end
      if (cap_two_take) begin
        cap_two_r      <= counter_r;
        cap_flag_two_r <= 1'b1;
      end
      if (match_one_fire) begin
        if (!mode_alt) cmp_flag_one_r <= 1'b1;
        if (ctrl_two_r[`TCC_C2_OUT_EN1]) compare_pin_one <= ctrl_one_r[`TCC_C1_LVL1];
      end
      if (match_two_fire) begin
        if (!ctrl_two_r[`TCC_C2_PWM]) cmp_flag_two_r <= 1'b1;
        if (ctrl_two_r[`TCC_C2_OUT_EN2]) compare_pin_two <= ctrl_one_r[`TCC_C1_LVL2];
      end
      if (!mode_alt) begin
        if (ctrl_one_r[`TCC_C1_FORCE1] && ctrl_two_r[`TCC_C2_OUT_EN1])
          compare_pin_one <= ctrl_one_r[`TCC_C1_LVL1];
        if (ctrl_one_r[`TCC_C1_FORCE2] && ctrl_two_r[`TCC_C2_OUT_EN2])
          compare_pin_two <= ctrl_one_r[`TCC_C1_LVL2];
      end
      compare_pin_one_oe <= ctrl_two_r[`TCC_C2_OUT_EN1];
      compare_pin_two_oe <= ctrl_two_r[`TCC_C2_OUT_EN2];
      // combined request, held pending while masked
      timer_irq <= ~cpu_mask &
                   ((ctrl_one_r[`TCC_C1_CAP_IE] & (cap_flag_one_r | cap_flag_two_r)) |
                    (ctrl_one_r[`TCC_C1_CMP_IE] & (cmp_flag_one_r | cmp_flag_two_r)) |
                    (ctrl_one_r[`TCC_C1_OVF_IE] & ovf_flag_r));
    end
  end
endmodule // tcc_timer_capture_compare

// [verification/tcc_pin_model.sv]
// Purpose: far side of the capture pins
// Assumes: pins are asynchronous to aclk
// Notes:   external clock pin held still
`timescale 1ns/10ps
module tcc_pin_model (
  output reg capture_pin_one,
  output reg capture_pin_two,
  output reg ext_clk_pin
);
  initial begin
    capture_pin_one = 1'b0;
    capture_pin_two = 1'b0;
    ext_clk_pin     = 1'b0;
  end
  // edges land off the clock grid
  task set_pin(input integer ch, input lvl);
    begin
      #37;
      if (ch == 1) capture_pin_one = lvl;
      else capture_pin_two = lvl;
    end
  endtask
endmodule // tcc_pin_model

// [verification/tcc_timer_capture_compare_properties.sv]
// Purpose: port checks of the capture/compare block
// Assumes: one aclk domain, aresetn synchronous low
// Notes:   bound to the design top
`timescale 1ns/10ps
module tcc_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        cpu_mask,
  input wire        compare_pin_one,
  input wire        compare_pin_one_oe,
  input wire        compare_pin_two,
  input wire        compare_pin_two_oe,
  input wire        timer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_out;
    disable iff (1'b0) !aresetn |=> !(compare_pin_one | compare_pin_two | compare_pin_one_oe | compare_pin_two_oe);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not low in reset");
  property p_mask_irq;
    cpu_mask [*3] |-> !timer_irq;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("irq while masked");
  property p_gpio_one;
    !compare_pin_one_oe && $past(!compare_pin_one_oe) |-> $stable(compare_pin_one);
  endproperty
  a_gpio_one: assert property (p_gpio_one) else $error("pin one moved with output off");
  property p_gpio_two;
    !compare_pin_two_oe && $past(!compare_pin_two_oe) |-> $stable(compare_pin_two);
  endproperty
  a_gpio_two: assert property (p_gpio_two) else $error("pin two moved with output off");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
endmodule // tcc_props
bind tcc_timer_capture_compare tcc_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_mask,
  .compare_pin_one, .compare_pin_one_oe, .compare_pin_two, .compare_pin_two_oe, .timer_irq);

// [verification/timer_capture_compare_tb_top.sv]
// Purpose: self-checking bench of the capture/compare block
// Assumes: 10 MHz aclk, prescaler /2 except the /4 scenario
// Notes:   capture pins come from the pin model
`timescale 1ns/10ps
`include "tcc_defines.vh"
module timer_capture_compare_tb_top;
  reg         aclk, aresetn, cpu_mask, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, v;
  reg  [15:0] x, c0, c1;
  reg  [1:0]  r;
  wire        awready, wready, bvalid, arready, rvalid, cp1, cp2, ext, cmp1, cmp1_oe, cmp2, cmp2_oe, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     err_total, n_tests, i;
  tcc_timer_capture_compare i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_pin_one(cp1), .capture_pin_two(cp2), .ext_clk_pin(ext), .cpu_mask(cpu_mask),
    .compare_pin_one(cmp1), .compare_pin_one_oe(cmp1_oe), .compare_pin_two(cmp2),
    .compare_pin_two_oe(cmp2_oe), .timer_irq(irq));
  tcc_pin_model i_pins (.capture_pin_one(cp1), .capture_pin_two(cp2), .ext_clk_pin(ext));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %0s exp %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      r = 2'h3;
      for (n = 0; n < 40 && r === 2'h3; n = n + 1) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          r = bresp;
          bready <= 1'b0;
        end
      end
      if (r === 2'h3) chk("wr_tmo", 32'h1, 32'h0);
      if (r === 2'h3) finish_test;
    end
  endtask
  task rd(input [7:0] a);
    integer n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 2'h3;
      for (n = 0; n < 40 && r === 2'h3; n = n + 1) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          v = rdata;
          r = rresp;
          rready <= 1'b0;
        end
      end
      if (r === 2'h3) chk("rd_tmo", 32'h1, 32'h0);
      if (r === 2'h3) finish_test;
    end
  endtask
  task rd16(input [7:0] hi, input [7:0] lo);
    begin
      rd(hi);
      x[15:8] = v[7:0];
      rd(lo);
      x[7:0] = v[7:0];
    end
  endtask
  task pin(input integer ch, input l);
    begin
      i_pins.set_pin(ch, l);
      cyc(10);
    end
  endtask
  task t_reset;
    begin
      chk("pins_rst", {cmp1, cmp2, cmp1_oe, cmp2_oe, irq}, 32'h0);
      rd16(`TCC_OFS_CMP1_HI, `TCC_OFS_CMP1_LO);
      chk("cmp1_rst", x, `TCC_CMP_RESET);
      rd16(`TCC_OFS_CMP2_HI, `TCC_OFS_CMP2_LO);
      chk("cmp2_rst", x, `TCC_CMP_RESET);
      wr(`TCC_OFS_CMP1_HI, 32'h12);
      wr(`TCC_OFS_CMP1_LO, 32'h34);
      rd16(`TCC_OFS_CMP1_HI, `TCC_OFS_CMP1_LO);
      chk("cmp1_rw", x, 32'h1234);
      rd16(`TCC_OFS_CAP1_HI, `TCC_OFS_CAP1_LO);
      c0 = x;
      wr(`TCC_OFS_CAP1_HI, 32'hA5);
      wr(`TCC_OFS_CAP1_LO, 32'h5A);
      rd16(`TCC_OFS_CAP1_HI, `TCC_OFS_CAP1_LO);
      chk("cap1_ro", x, c0);
      rd(8'h3C);
      chk("rd_unmap", r, `TCC_RESP_SLVERR);
      wr(8'h3C, 32'h1);
      chk("wr_unmap", r, `TCC_RESP_SLVERR);
    end
  endtask
  task t_force;
    begin
      wr(`TCC_OFS_CTRL_TWO, 32'h40);
      wr(`TCC_OFS_CTRL_ONE, 32'h14);
      cyc(4);
      chk("frc_pin", {cmp2_oe, cmp2}, 32'h3);
      rd(`TCC_OFS_STATUS);
      chk("frc_flag", v[`TCC_ST_CMP2], 32'h0);
      wr(`TCC_OFS_CTRL_TWO, 32'h50);
      wr(`TCC_OFS_CTRL_ONE, 32'h10);
      cyc(4);
      chk("frc_pwm", cmp2, 32'h1);
      pin(1, 1'b1);
      pin(1, 1'b0);
      rd(`TCC_OFS_STATUS);
      chk("pwm_cap1", v[`TCC_ST_CAP1], 32'h0);
      wr(`TCC_OFS_CTRL_TWO, 32'h40);
      cyc(4);
      chk("frc_low", cmp2, 32'h0);
      wr(`TCC_OFS_CTRL_ONE, 32'h0);
      wr(`TCC_OFS_CTRL_TWO, 32'h0);
    end
  endtask
  task t_cap(input integer ch);
    reg [7:0] hi, lo;
    reg       e;
    integer   sb;
    begin
      hi = (ch == 1) ? `TCC_OFS_CAP1_HI : `TCC_OFS_CAP2_HI;
      lo = (ch == 1) ? `TCC_OFS_CAP1_LO : `TCC_OFS_CAP2_LO;
      sb = (ch == 1) ? `TCC_ST_CAP1 : `TCC_ST_CAP2;
      e = (ch == 2);
      wr(`TCC_OFS_CTRL_ONE, 32'h80);
      wr(`TCC_OFS_CTRL_TWO, {31'h0, e});
      pin(ch, e);
      rd(`TCC_OFS_STATUS);
      rd16(hi, lo);
      pin(ch, !e);
      rd(`TCC_OFS_STATUS);
      chk("cap_wrong", v[sb], 32'h0);
      rd16(`TCC_OFS_CNT_HI, `TCC_OFS_CNT_LO);
      c0 = x;
      pin(ch, e);
      rd16(`TCC_OFS_CNT_HI, `TCC_OFS_CNT_LO);
      c1 = x;
      rd(`TCC_OFS_STATUS);
      chk("cap_flag", v[sb], 32'h1);
      chk("irq_mask", irq, 32'h0);
      cpu_mask <= 1'b0;
      cyc(3);
      chk("irq_on", irq, 32'h1);
      rd16(hi, lo);
      chk("cap_val", x >= c0 && x <= c1, 32'h1);
      rd(`TCC_OFS_STATUS);
      chk("cap_clr", v[sb], 32'h0);
      cyc(3);
      chk("irq_off", irq, 32'h0);
      rd(hi);
      pin(ch, !e);
      pin(ch, e);
      rd(`TCC_OFS_STATUS);
      chk("cap_lock", v[sb], 32'h0);
      rd(lo);
      rd16(`TCC_OFS_CNT_HI, `TCC_OFS_CNT_LO);
      c0 = x;
      pin(ch, !e);
      pin(ch, e);
      rd(`TCC_OFS_STATUS);
      chk("cap_again", v[sb], 32'h1);
      rd16(hi, lo);
      chk("cap_new", x >= c0, 32'h1);
      cpu_mask <= 1'b1;
    end
  endtask
  task t_cmp;
    begin
      wr(`TCC_OFS_CMP1_HI, 32'h0);
      wr(`TCC_OFS_CMP1_LO, 32'h20);
      wr(`TCC_OFS_CMP2_HI, 32'h0);
      wr(`TCC_OFS_CTRL_TWO, 32'h80);
      wr(`TCC_OFS_CTRL_ONE, 32'h42);
      wr(`TCC_OFS_CNT_LO, 32'h0);
      rd16(`TCC_OFS_CNT_HI, `TCC_OFS_CNT_LO);
      chk("cnt_load", x >= `TCC_CNT_RESET || x < 16'h0008, 32'h1);
      for (i = 0; i < 300 && cmp1 !== 1'b1; i = i + 1) cyc(1);
      chk("cmp_pin", cmp1, 32'h1);
      rd(`TCC_OFS_STATUS);
      chk("cmp_st", v[6:3], 32'hC);
      cpu_mask <= 1'b0;
      cyc(3);
      chk("cmp_irq", irq, 32'h1);
      wr(`TCC_OFS_CMP2_LO, 32'h80);
      rd(`TCC_OFS_CMP1_LO);
      cyc(300);
      rd(`TCC_OFS_STATUS);
      chk("cmp1_clr", v[`TCC_ST_CMP1], 32'h0);
      chk("cmp2_hit", v[`TCC_ST_CMP2], 32'h1);
      chk("gpio_irq", {cmp2_oe, irq}, 32'h1);
    end
  endtask
  task t_presc;
    begin
      wr(`TCC_OFS_CTRL_ONE, 32'h0);
      wr(`TCC_OFS_CTRL_TWO, 32'h84);
      wr(`TCC_OFS_CNT_LO, 32'h0);
      wr(`TCC_OFS_CMP1_HI, 32'h0);
      wr(`TCC_OFS_CMP1_LO, 32'h10);
      for (i = 0; i < 300 && cmp1 !== 1'b0; i = i + 1) cyc(1);
      // pin seen one edge late, counter sampled three edges later
      rd16(`TCC_OFS_CNT_HI, `TCC_OFS_CNT_LO);
      chk("cmp_div4", x, 32'h11);
      c0 = x;
      cyc(200);
      // 208 clocks between the two high-byte reads
      rd16(`TCC_OFS_CNT_HI, `TCC_OFS_CNT_LO);
      chk("presc_div4", x - c0, 32'h34);
    end
  endtask
  initial begin
    err_total = 0;
    n_tests = 0;
    aresetn = 1'b0;
    cpu_mask = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_force;
    t_cap(1);
    t_cap(2);
    t_cmp;
    t_presc;
    finish_test;
  end
endmodule // timer_capture_compare_tb_top
